// ==== shared/osa_defines.vh ====
`ifndef OSA_DEFINES_VH
`define OSA_DEFINES_VH

// operation codes from decode
`define OSA_OP_NOP     4'h0
`define OSA_OP_ADD     4'h1
`define OSA_OP_ADD_WITH_CARRY_OP    4'h2
`define OSA_OP_AND     4'h3
`define OSA_OP_ASR     4'h4
`define OSA_OP_ACCADD  4'h5
`define OSA_OP_ACCWORD 4'h6
`define OSA_OP_SQR     4'h7
`define OSA_OP_MUL     4'h8
`define OSA_OP_DIV     4'h9

// operand forms
`define OSA_FORM_FILE  2'h0
`define OSA_FORM_LIT10 2'h1
`define OSA_FORM_THREE 2'h2
`define OSA_FORM_LIT5  2'h3

// prefetch modes
`define OSA_PF_NONE    4'h0
`define OSA_PF_PLAIN   4'h1
`define OSA_PF_INC2    4'h2
`define OSA_PF_INC4    4'h3
`define OSA_PF_INC6    4'h4
`define OSA_PF_DEC2    4'h5
`define OSA_PF_DEC4    4'h6
`define OSA_PF_DEC6    4'h7
`define OSA_PF_INDEX   4'h8

// working register numbers
`define OSA_W_XP0      4'h8
`define OSA_W_XP1      4'h9
`define OSA_W_YP0      4'hA
`define OSA_W_YP1      4'hB
`define OSA_W_INDEX    4'hC

// register map (byte addresses)
`define OSA_ADDR_WREG0  8'h00
`define OSA_ADDR_WREG15 8'h3C
`define OSA_ADDR_STATUS 8'h40
`define OSA_ADDR_ACCA_L 8'h44
`define OSA_ADDR_ACCA_H 8'h48
`define OSA_ADDR_ACCB_L 8'h4C
`define OSA_ADDR_ACCB_H 8'h50

// status bit positions
`define OSA_ST_C   0
`define OSA_ST_DC  1
`define OSA_ST_N   2
`define OSA_ST_OV  3
`define OSA_ST_Z   4
`define OSA_ST_OA  5
`define OSA_ST_OB  6
`define OSA_ST_SA  7
`define OSA_ST_SB  8
`define OSA_ST_RESET 9'h000

// instruction word layout
`define OSA_INSTR_BITS  24
`define OSA_OPCODE_BITS 8

`endif

// ==== core/osa_add16.v ====
`timescale 1ns/10ps
`default_nettype none
module osa_add16 (
  input  wire [15:0] opa,
  input  wire [15:0] opb,
  input  wire        cin,
  output wire [15:0] sum,
  output wire        carry,
  output wire        digit_carry,
  output wire        overflow
);
  wire [16:0] full;
  wire [4:0]  low;

  assign full        = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
  assign low         = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  assign sum         = full[15:0];
  assign carry       = full[16];
  assign digit_carry = low[4];
  // signed overflow: like-signed operands give an unlike-signed sum
  assign overflow    = (opa[15] == opb[15]) && (full[15] != opa[15]);
endmodule // osa_add16
`default_nettype wire

// ==== core/osa_prefetch_agu.v ====
`timescale 1ns/10ps
`include "osa_defines.vh"
`default_nettype none
module osa_prefetch_agu (
  input  wire [15:0] ptr0,
  input  wire [15:0] ptr1,
  input  wire [15:0] index,
  input  wire        ptr_sel,
  input  wire [3:0]  mode,
  output reg  [15:0] addr,
  output reg         req,
  output reg         upd,
  output wire        upd_sel,
  output reg  [15:0] upd_val
);
  reg  [15:0] delta;
  wire [15:0] base;

  assign base    = ptr_sel ? ptr1 : ptr0;
  assign upd_sel = ptr_sel;

  always @* begin
    delta = 16'h0000;
    upd   = 1'b1;
    req   = 1'b1;
    addr  = base;
    case (mode)
      `OSA_PF_NONE: begin
        req = 1'b0;
        upd = 1'b0;
      end
      `OSA_PF_PLAIN: upd = 1'b0;
      `OSA_PF_INC2:  delta = 16'h0002;
      `OSA_PF_INC4:  delta = 16'h0004;
      `OSA_PF_INC6:  delta = 16'h0006;
      `OSA_PF_DEC2:  delta = 16'hFFFE;
      `OSA_PF_DEC4:  delta = 16'hFFFC;
      `OSA_PF_DEC6:  delta = 16'hFFFA;
      `OSA_PF_INDEX: begin
        // indexed form always uses the second pointer plus the index register
        addr = ptr1 + index;
        upd  = 1'b0;
      end
      default: begin
        req = 1'b0;
        upd = 1'b0;
      end
    endcase
    upd_val = base + delta;
  end
endmodule // osa_prefetch_agu
`default_nettype wire

// ==== core/osa_core.v ====
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "osa_defines.vh"
`default_nettype none
module osa_core #(
  parameter ACC_W = 40
) (
  input  wire                       pclk,
  input  wire                       presetn,
  input  wire                       psel,
  input  wire                       penable,
  input  wire                       pwrite,
  input  wire [7:0]                 paddr,
  input  wire [31:0]                pwdata,
  output reg  [31:0]                prdata,
  output reg                        pready,
  output reg                        pslverr,
  input  wire                       op_valid,
  input  wire [`OSA_INSTR_BITS-1:0] op_word,
  input  wire [3:0]                 op_code,
  input  wire [1:0]                 op_form,
  input  wire                       op_to_w0,
  input  wire [3:0]                 base_operand_reg,
  input  wire [3:0]                 source_operand_reg,
  input  wire [3:0]                 dest_operand_reg,
  input  wire [9:0]                 op_literal,
  input  wire                       acc_sel,
  input  wire [3:0]                 acc_shift,
  input  wire [3:0]                 mpy_m,
  input  wire [3:0]                 mpy_n,
  input  wire [15:0]                file_rdata,
  input  wire [3:0]                 x_mode,
  input  wire                       x_ptr_sel,
  input  wire [1:0]                 x_dest,
  input  wire [3:0]                 y_mode,
  input  wire                       y_ptr_sel,
  input  wire [1:0]                 y_dest,
  input  wire                       x_data_valid,
  input  wire [15:0]                x_data,
  input  wire                       y_data_valid,
  input  wire [15:0]                y_data,
  output reg                        file_we,
  output reg  [15:0]                file_wdata,
  output reg                        mul_valid,
  output reg  [15:0]                mul_a,
  output reg  [15:0]                mul_b,
  output reg                        div_valid,
  output reg  [15:0]                div_a,
  output reg  [15:0]                div_b,
  output reg                        op_err,
  output reg                        x_req,
  output reg  [15:0]                x_addr,
  output reg                        y_req,
  output reg  [15:0]                y_addr,
  output reg  [`OSA_OPCODE_BITS-1:0] last_opcode,
  output reg  [8:0]                 status_flags
);
  reg  [15:0]      implicit_working_zero [0:15];
  reg  [ACC_W-1:0] acc_a;
  reg  [ACC_W-1:0] acc_b;
  reg  [1:0]       x_dest_q;
  reg  [1:0]       y_dest_q;
  reg  [15:0]      opa;
  reg  [15:0]      opb;
  reg  [15:0]      result;
  reg  [3:0]       res_idx;
  reg              res_to_file;
  reg              res_en;
  reg  [31:0]      rd_mux;
  reg              rd_err;
  reg  [ACC_W-1:0] acc_addend;
  reg  [ACC_W-1:0] acc_new;
  reg  [3:0]       shl_amt;
  reg              pair_ok;
  integer          i;

  wire [15:0]      add_sum;
  wire             add_c;
  wire             add_dc;
  wire             add_ov;
  wire             is_add;
  wire             is_acc;
  wire             cin;
  wire [ACC_W-1:0] acc_cur;
  wire [ACC_W:0]   acc_sum;
  wire             acc_wrap;
  wire             acc_guard;
  wire [ACC_W-1:0] acc_word;
  wire [ACC_W-1:0] acc_max;
  wire [ACC_W-1:0] acc_min;
  wire             m_hi;
  wire             n_hi;
  wire             apb_setup;
  wire             apb_wr;
  wire [3:0]       reg_idx;
  wire             reg_hit;
  wire [15:0]      x_addr_c;
  wire             x_req_c;
  wire             x_upd;
  wire             x_upd_sel;
  wire [15:0]      x_upd_val;
  wire [15:0]      y_addr_c;
  wire             y_req_c;
  wire             y_upd;
  wire             y_upd_sel;
  wire [15:0]      y_upd_val;

  assign is_add    = (op_code == `OSA_OP_ADD) || (op_code == `OSA_OP_ADD_WITH_CARRY_OP);
  assign is_acc    = (op_code == `OSA_OP_ACCADD) || (op_code == `OSA_OP_ACCWORD);
  assign cin       = (op_code == `OSA_OP_ADD_WITH_CARRY_OP) & status_flags[`OSA_ST_C];
  assign acc_cur   = acc_sel ? acc_b : acc_a;
  assign acc_sum   = {acc_cur[ACC_W-1], acc_cur} + {acc_addend[ACC_W-1], acc_addend};
  assign acc_wrap  = acc_sum[ACC_W] ^ acc_sum[ACC_W-1];
  assign acc_guard = ~(&acc_new[ACC_W-1:31] | ~|acc_new[ACC_W-1:31]);
  assign acc_word  = {{(ACC_W-32){source_operand_word(source_operand_reg)}},
                      implicit_working_zero[source_operand_reg], 16'h0000};
  assign acc_max   = {1'b0, {(ACC_W-1){1'b1}}};
  assign acc_min   = {1'b1, {(ACC_W-1){1'b0}}};
  assign m_hi      = (mpy_m[3:2] == 2'b01);
  assign n_hi      = (mpy_n[3:2] == 2'b01);
  assign apb_setup = psel & penable & ~pready;
  assign apb_wr    = psel & penable & pready & pwrite;
  assign reg_idx   = paddr[5:2];
  assign reg_hit   = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00);

  // sign bit of the selected source word, used for accumulator extension
  function source_operand_word;
    input [3:0] sel;
    begin
      source_operand_word = 1'b0;
      source_operand_word = implicit_working_zero[sel][15];
    end
  endfunction

  osa_add16 u_add (
    .opa         (opa),
    .opb         (opb),
    .cin         (cin),
    .sum         (add_sum),
    .carry       (add_c),
    .digit_carry (add_dc),
    .overflow    (add_ov)
  );

  osa_prefetch_agu u_xagu (
    .ptr0    (implicit_working_zero[`OSA_W_XP0]),
    .ptr1    (implicit_working_zero[`OSA_W_XP1]),
    .index   (implicit_working_zero[`OSA_W_INDEX]),
    .ptr_sel (x_ptr_sel),
    .mode    (x_mode),
    .addr    (x_addr_c),
    .req     (x_req_c),
    .upd     (x_upd),
    .upd_sel (x_upd_sel),
    .upd_val (x_upd_val)
  );

  osa_prefetch_agu u_yagu (
    .ptr0    (implicit_working_zero[`OSA_W_YP0]),
    .ptr1    (implicit_working_zero[`OSA_W_YP1]),
    .index   (implicit_working_zero[`OSA_W_INDEX]),
    .ptr_sel (y_ptr_sel),
    .mode    (y_mode),
    .addr    (y_addr_c),
    .req     (y_req_c),
    .upd     (y_upd),
    .upd_sel (y_upd_sel),
    .upd_val (y_upd_val)
  );

  // operand selection per form
  always @* begin
    opa = implicit_working_zero[base_operand_reg];
    opb = implicit_working_zero[source_operand_reg];
    case (op_form)
      `OSA_FORM_FILE: begin
        opa = file_rdata;
        opb = implicit_working_zero[0];
      end
      `OSA_FORM_LIT10: begin
        opa = implicit_working_zero[dest_operand_reg];
        opb = {6'h00, op_literal};
      end
      `OSA_FORM_THREE: begin
        opa = implicit_working_zero[base_operand_reg];
        opb = implicit_working_zero[source_operand_reg];
      end
      `OSA_FORM_LIT5: begin
        opa = implicit_working_zero[base_operand_reg];
        opb = {11'h000, op_literal[4:0]};
      end
      default: begin
        opa = implicit_working_zero[base_operand_reg];
        opb = implicit_working_zero[source_operand_reg];
      end
    endcase
  end

  // result and destination
  always @* begin
    result = add_sum;
    res_en = op_valid & (is_add | (op_code == `OSA_OP_AND));
    case (op_code)
      `OSA_OP_AND: result = opa & opb;
      `OSA_OP_ASR: result = {opa[15], opa[15:1]};
      default:     result = add_sum;
    endcase
    if (op_valid && (op_code == `OSA_OP_ASR) && (op_form == `OSA_FORM_FILE))
      res_en = 1'b1;
    res_to_file = (op_form == `OSA_FORM_FILE) & ~op_to_w0;
    if (op_form == `OSA_FORM_FILE)
      res_idx = 4'h0;
    else
      res_idx = dest_operand_reg;
  end

  // accumulator addend: other accumulator, or shifted signed word
  always @* begin
    shl_amt    = 4'h0 - acc_shift;
    acc_addend = acc_sel ? acc_a : acc_b;
    if (op_code == `OSA_OP_ACCWORD) begin
      acc_addend = acc_word;
      if (acc_shift[3])
        acc_addend = acc_addend << shl_amt;
      else
        acc_addend = $signed(acc_addend) >>> acc_shift;
    end
    acc_new = acc_sum[ACC_W-1:0];
    if (acc_wrap)
      acc_new = acc_sum[ACC_W] ? acc_min : acc_max;
  end

  // multiplier pair legality
  always @* begin
    pair_ok = 1'b0;
    if (op_code == `OSA_OP_SQR)
      pair_ok = m_hi && (mpy_m == mpy_n);
    else if (op_code == `OSA_OP_MUL)
      pair_ok = m_hi && n_hi && (mpy_m < mpy_n);
  end

  // register read mux
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (reg_hit)
      rd_mux = {16'h0000, implicit_working_zero[reg_idx]};
    else begin
      case (paddr)
        `OSA_ADDR_STATUS: rd_mux = {23'h000000, status_flags};
        `OSA_ADDR_ACCA_L: rd_mux = acc_a[31:0];
        `OSA_ADDR_ACCA_H: rd_mux = {{(64-ACC_W){1'b0}}, acc_a[ACC_W-1:32]};
        `OSA_ADDR_ACCB_L: rd_mux = acc_b[31:0];
        `OSA_ADDR_ACCB_H: rd_mux = {{(64-ACC_W){1'b0}}, acc_b[ACC_W-1:32]};
        default:          rd_err = 1'b1;
      endcase
    end
  end

  // bus slave: one wait state, answer on the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & rd_err;
      if (apb_setup && !pwrite)
        prdata <= rd_mux;
    end
  end

  // working registers: instruction, pointer update, prefetch data, bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 16; i = i + 1)
        implicit_working_zero[i] <= 16'h0000;
    end else begin
      if (res_en && !res_to_file)
        implicit_working_zero[res_idx] <= result;
      if (op_valid && x_upd)
        implicit_working_zero[{3'b100, x_upd_sel}] <= x_upd_val;
      if (op_valid && y_upd)
        implicit_working_zero[{3'b101, y_upd_sel}] <= y_upd_val;
      if (x_data_valid)
        implicit_working_zero[{2'b01, x_dest_q}] <= x_data;
      if (y_data_valid)
        implicit_working_zero[{2'b01, y_dest_q}] <= y_data;
      if (apb_wr && reg_hit)
        implicit_working_zero[reg_idx] <= pwdata[15:0];
    end
  end

  // accumulators and status flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_a        <= {ACC_W{1'b0}};
      acc_b        <= {ACC_W{1'b0}};
      status_flags <= `OSA_ST_RESET;
    end else begin
      if (op_valid && is_acc) begin
        if (acc_sel) begin
          acc_b <= acc_new;
          status_flags[`OSA_ST_OB] <= acc_guard;
          if (acc_wrap)
            status_flags[`OSA_ST_SB] <= 1'b1;
        end else begin
          acc_a <= acc_new;
          status_flags[`OSA_ST_OA] <= acc_guard;
          if (acc_wrap)
            status_flags[`OSA_ST_SA] <= 1'b1;
        end
      end
      if (res_en) begin
        status_flags[`OSA_ST_N] <= result[15];
        status_flags[`OSA_ST_Z] <= (result == 16'h0000);
        if (is_add) begin
          status_flags[`OSA_ST_C]  <= add_c;
          status_flags[`OSA_ST_DC] <= add_dc;
          status_flags[`OSA_ST_OV] <= add_ov;
        end else if (op_code == `OSA_OP_ASR) begin
          status_flags[`OSA_ST_C]  <= opa[0];
          status_flags[`OSA_ST_OV] <= 1'b0;
        end
      end
      if (apb_wr && (paddr == `OSA_ADDR_STATUS))
        status_flags <= pwdata[8:0];
      // sticky saturation beats a software clear
      if (op_valid && is_acc && acc_wrap)
        status_flags[acc_sel ? `OSA_ST_SB : `OSA_ST_SA] <= 1'b1;
    end
  end

  // datapath outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_we     <= 1'b0;
      file_wdata  <= 16'h0000;
      mul_valid   <= 1'b0;
      mul_a       <= 16'h0000;
      mul_b       <= 16'h0000;
      div_valid   <= 1'b0;
      div_a       <= 16'h0000;
      div_b       <= 16'h0000;
      op_err      <= 1'b0;
      x_req       <= 1'b0;
      x_addr      <= 16'h0000;
      y_req       <= 1'b0;
      y_addr      <= 16'h0000;
      x_dest_q    <= 2'h0;
      y_dest_q    <= 2'h0;
      last_opcode <= {`OSA_OPCODE_BITS{1'b0}};
    end else begin
      file_we   <= res_en & res_to_file;
      mul_valid <= op_valid & pair_ok;
      div_valid <= op_valid & (op_code == `OSA_OP_DIV);
      op_err    <= op_valid & ((op_code == `OSA_OP_SQR) | (op_code == `OSA_OP_MUL)) & ~pair_ok;
      x_req     <= op_valid & x_req_c;
      y_req     <= op_valid & y_req_c;
      if (res_en)
        file_wdata <= result;
      if (op_valid) begin
        last_opcode <= op_word[`OSA_INSTR_BITS-1:`OSA_INSTR_BITS-`OSA_OPCODE_BITS];
        if (pair_ok) begin
          mul_a <= implicit_working_zero[mpy_m];
          mul_b <= implicit_working_zero[mpy_n];
        end
        if (op_code == `OSA_OP_DIV) begin
          div_a <= implicit_working_zero[mpy_m];
          div_b <= implicit_working_zero[mpy_n];
        end
        if (x_req_c) begin
          x_addr   <= x_addr_c;
          x_dest_q <= x_dest;
        end
        if (y_req_c) begin
          y_addr   <= y_addr_c;
          y_dest_q <= y_dest;
        end
      end
    end
  end
endmodule // osa_core
`default_nettype wire

// ==== bench/osa_core_monitor.sv ====
`timescale 1ns/10ps
`include "osa_defines.vh"
`default_nettype none
module osa_core_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        op_valid,
  input wire logic [23:0] op_word,
  input wire logic [3:0]  op_code,
  input wire logic [1:0]  op_form,
  input wire logic [3:0]  mpy_m,
  input wire logic [3:0]  mpy_n,
  input wire logic [15:0] file_rdata,
  input wire logic [3:0]  x_mode,
  input wire logic [3:0]  y_mode,
  input wire logic        mul_valid,
  input wire logic        op_err,
  input wire logic        div_valid,
  input wire logic        x_req,
  input wire logic        y_req,
  input wire logic [7:0]  last_opcode,
  input wire logic [8:0]  status_flags
);
  logic mul_op;
  logic mul_ok;
  logic sw_wr;
  assign mul_op = op_valid && op_code == `OSA_OP_MUL;
  assign mul_ok = mpy_m[3:2] == 2'h1 && mpy_n[3:2] == 2'h1 && mpy_m < mpy_n;
  // a software status write in the same cycle may legally override flags
  assign sw_wr = psel && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer missing");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_SQR_BAD: assert property (op_valid && op_code == `OSA_OP_SQR &&
    (mpy_m != mpy_n || mpy_m[3:2] != 2'h1) |=> op_err && !mul_valid)
    else $error("bad square pair accepted");
  AST_MUL_OK: assert property (mul_op && mul_ok |=> mul_valid && !op_err)
    else $error("legal multiply pair refused");
  AST_MUL_BAD: assert property (mul_op && !mul_ok |=> op_err && !mul_valid)
    else $error("bad multiply pair accepted");
  AST_DIV_GO: assert property (op_valid && op_code == `OSA_OP_DIV |=> div_valid)
    else $error("divide operands not issued");
  AST_NO_PF: assert property (op_valid && x_mode == 4'h0 && y_mode == 4'h0
    |=> !x_req && !y_req)
    else $error("prefetch without mode");
  AST_ACC_FLAGS: assert property (op_valid && !sw_wr &&
    (op_code == `OSA_OP_ACCADD || op_code == `OSA_OP_ACCWORD)
    |=> $stable(status_flags & 9'h01F))
    else $error("acc op touched core flags");
  AST_AND_FLAGS: assert property (op_valid && op_code == `OSA_OP_AND && !sw_wr
    |=> $stable(status_flags & 9'h1EB))
    else $error("and touched other flags");
  AST_ASR: assert property (op_valid && op_code == `OSA_OP_ASR && !sw_wr &&
    op_form == 2'h0 |=> !status_flags[3] && status_flags[0] == $past(file_rdata[0]))
    else $error("shift flags wrong");
  AST_OPCODE: assert property (op_valid |=> last_opcode == $past(op_word[23:16]))
    else $error("opcode field not kept");
endmodule // osa_core_monitor
bind osa_core osa_core_monitor osa_core_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .op_valid(op_valid),
  .op_word(op_word), .op_code(op_code), .op_form(op_form), .mpy_m(mpy_m), .mpy_n(mpy_n),
  .file_rdata(file_rdata), .x_mode(x_mode), .y_mode(y_mode), .mul_valid(mul_valid),
  .op_err(op_err), .div_valid(div_valid), .x_req(x_req), .y_req(y_req),
  .last_opcode(last_opcode), .status_flags(status_flags));
`default_nettype wire

// ==== bench/osa_pf_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module osa_pf_port (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        req,
  input  wire logic [15:0] addr,
  input  wire logic        slow,
  output var  logic        vld,
  output var  logic [15:0] data
);
  logic [1:0]  wait_cnt;
  logic        busy;
  logic [15:0] hold;
  // data bus carries junk outside a returned word
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {vld, data, wait_cnt, busy, hold} <= '0;
    end else begin
      vld <= 1'b0;
      data <= data + 16'h3B71;
      if (req) begin
        busy <= 1'b1;
        hold <= ~addr;
        wait_cnt <= slow ? 2'h2 : 2'h0;
      end else if (busy && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (busy) begin
        vld <= 1'b1;
        data <= hold;
        busy <= 1'b0;
      end
    end
  end
endmodule // osa_pf_port
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`include "osa_defines.vh"
`default_nettype none
`define OSA_CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, op_valid, op_to_w0, acc_sel, slow;
  logic        x_ptr_sel, y_ptr_sel;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [23:0] op_word;
  logic [3:0]  op_code, base_operand_reg, source_operand_reg, dest_operand_reg, acc_shift;
  logic [3:0]  mpy_m, mpy_n, x_mode, y_mode;
  logic [1:0]  op_form, x_dest, y_dest;
  logic [9:0]  op_literal;
  logic [15:0] file_rdata;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, file_we, mul_valid, div_valid, op_err, x_req, y_req;
  wire logic        x_data_valid, y_data_valid;
  wire logic [15:0] file_wdata, mul_a, mul_b, div_a, div_b, x_addr, y_addr, x_data, y_data;
  wire logic [7:0]  last_opcode;
  wire logic [8:0]  status_flags;
  integer seed = 32'h5EFC, checks = 0, failures = 0, i, k;
  logic [15:0] w [16];
  logic [8:0]  st;
  logic [31:0] q [$];
  logic [24:0] r;

  osa_core osa_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_word(op_word), .op_code(op_code),
    .op_form(op_form), .op_to_w0(op_to_w0), .base_operand_reg(base_operand_reg),
    .source_operand_reg(source_operand_reg), .dest_operand_reg(dest_operand_reg),
    .op_literal(op_literal), .acc_sel(acc_sel), .acc_shift(acc_shift), .mpy_m(mpy_m),
    .mpy_n(mpy_n), .file_rdata(file_rdata), .x_mode(x_mode), .x_ptr_sel(x_ptr_sel),
    .x_dest(x_dest), .y_mode(y_mode), .y_ptr_sel(y_ptr_sel), .y_dest(y_dest),
    .x_data_valid(x_data_valid), .x_data(x_data), .y_data_valid(y_data_valid),
    .y_data(y_data), .file_we(file_we), .file_wdata(file_wdata), .mul_valid(mul_valid),
    .mul_a(mul_a), .mul_b(mul_b), .div_valid(div_valid), .div_a(div_a), .div_b(div_b),
    .op_err(op_err), .x_req(x_req), .x_addr(x_addr), .y_req(y_req), .y_addr(y_addr),
    .last_opcode(last_opcode), .status_flags(status_flags));
  osa_pf_port osa_pf_port_i [1:0] (.clk(pclk), .rstn(presetn), .req({y_req, x_req}),
    .addr({y_addr, x_addr}), .slow(slow), .vld({y_data_valid, x_data_valid}),
    .data({y_data, x_data}));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task test_done;
    failures += q.size();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task cmp(input logic [31:0] v);
    logic [31:0] e;
    e = (q.size() > 0) ? q.pop_front() : ~v;
    `OSA_CHK(v, e)
  endtask

  always @(posedge pclk) if (presetn) begin
    if (file_we) cmp({16'h0, file_wdata});
    if (mul_valid) cmp({mul_a, mul_b});
    if (div_valid) cmp({div_a, div_b});
    if (x_req) cmp({16'h0, x_addr});
    if (y_req) cmp({16'h0, y_addr});
    if (psel && penable && pready && !pwrite) cmp(prdata);
    if (psel && penable && pready) `OSA_CHK(pslverr, paddr > 8'h50)
  end

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task go(input logic [3:0] c);
    @(posedge pclk);
    {op_code, op_word, op_valid} <= {c, 24'($random(seed)), 1'b1};
    @(posedge pclk);
    {op_valid, x_mode, y_mode} <= '0;
  endtask

  function automatic logic [24:0] calc(input logic [3:0] c, input logic [15:0] x, y,
                                       input logic [8:0] s);
    logic [16:0] t;
    logic [4:0]  h;
    logic        ci;
    ci = c == `OSA_OP_ADD_WITH_CARRY_OP && s[0];
    t = x + y + 17'(ci);
    h = x[3:0] + y[3:0] + 5'(ci);
    if (c == `OSA_OP_AND) t = {1'b0, x & y};
    if (c == `OSA_OP_ASR) t = {x[0], x[15], x[15:1]};
    calc = {s[8:5], t[15:0] == 16'h0, x[15] == y[15] && t[15] != x[15], t[15], h[4], t[16],
            t[15:0]};
    if (c == `OSA_OP_AND) calc[19:16] = {s[3], t[15], s[1], s[0]};
    if (c == `OSA_OP_ASR) calc[19:16] = {1'b0, t[15], s[1], t[16]};
  endfunction

  function automatic logic [15:0] dl(input logic [3:0] md);
    if (md < 4'h2 || md > 4'h7) dl = 16'h0;
    else if (md < 4'h5) dl = {11'h0, md - 4'h1, 1'b0};
    else dl = -{11'h0, md - 4'h4, 1'b0};
  endfunction

  task arith(input logic [3:0] c, input logic [1:0] f);
    logic [3:0]  b, s, d;
    logic [9:0]  l;
    logic [15:0] fv, x, y;
    {b, s, d, l} = 22'($random(seed));
    fv = 16'($random(seed));
    if (f == `OSA_FORM_LIT10) b = d;
    x = (f == `OSA_FORM_FILE) ? fv : w[b];
    y = (f == `OSA_FORM_FILE) ? w[0] : (f == `OSA_FORM_THREE) ? w[s] :
        (f == `OSA_FORM_LIT5) ? {11'h0, l[4:0]} : {6'h0, l};
    r = calc(c, x, y, st);
    st = r[24:16];
    if (f == `OSA_FORM_FILE && !s[0]) q.push_back({16'h0, r[15:0]});
    {op_form, op_to_w0, base_operand_reg, source_operand_reg} <= {f, s[0], b, s};
    {dest_operand_reg, op_literal, file_rdata} <= {d, l, fv};
    go(c);
    if (f != `OSA_FORM_FILE || s[0]) begin
      d = (f == `OSA_FORM_FILE) ? 4'h0 : d;
      w[d] = r[15:0];
      rd({2'h0, d, 2'h0}, {16'h0, w[d]});
    end
    rd(`OSA_ADDR_STATUS, {23'h0, st});
  endtask

  task pf(input logic [3:0] xm, input logic [3:0] ym);
    logic [1:0]  xd;
    logic        xs, ys;
    logic [3:0]  m, n, xp, yp;
    logic [15:0] xa, ya;
    {xd, xs, ys, m[1:0], n[1:0]} = 8'($random(seed));
    {m[3:2], n[3:2]} = 4'h5;
    xp = (xm == `OSA_PF_INDEX) ? `OSA_W_XP1 : {3'h4, xs};
    yp = (ym == `OSA_PF_INDEX) ? `OSA_W_YP1 : {3'h5, ys};
    xa = (xm == `OSA_PF_INDEX) ? w[9] + w[12] : w[xp];
    ya = (ym == `OSA_PF_INDEX) ? w[11] + w[12] : w[yp];
    if (m < n) q.push_back({w[m], w[n]});
    if (xm != 4'h0) q.push_back({16'h0, xa});
    if (ym != 4'h0) q.push_back({16'h0, ya});
    w[xp] = w[xp] + dl(xm);
    w[yp] = w[yp] + dl(ym);
    {mpy_m, mpy_n, x_mode, x_ptr_sel, x_dest} <= {m, n, xm, xs, xd};
    {y_mode, y_ptr_sel, y_dest} <= {ym, ys, ~xd};
    go(`OSA_OP_MUL);
    repeat (6) @(posedge pclk);
    if (xm != 4'h0) w[{2'h1, xd}] = ~xa;
    if (ym != 4'h0) w[{2'h1, ~xd}] = ~ya;
    for (k = 4; k < 12; k++) rd(8'(k * 4), {16'h0, w[k]});
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, op_valid, op_word, op_code, op_form} = '0;
    {op_to_w0, base_operand_reg, source_operand_reg, dest_operand_reg, op_literal} = '0;
    {acc_sel, acc_shift, mpy_m, mpy_n, file_rdata, slow} = '0;
    {x_mode, x_ptr_sel, x_dest, y_mode, y_ptr_sel, y_dest} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OSA_ADDR_STATUS, 32'h0);
    for (i = 0; i < 16; i++) begin
      w[i] = 16'($random(seed));
      apb(1'b1, 8'(i * 4), {16'h0, w[i]});
    end
    for (i = 0; i < 16; i++) rd(8'(i * 4), {16'h0, w[i]});
    rd(8'h54, 32'h0);
    st = 9'($random(seed));
    apb(1'b1, `OSA_ADDR_STATUS, {23'h0, st});
    for (i = 0; i < 12; i++) arith(4'(1 + i / 4), 2'(i));
    repeat (3) arith(`OSA_OP_ASR, `OSA_FORM_FILE);
    for (i = 0; i < 9; i++) begin
      slow <= i[0];
      pf(4'(i), 4'(8 - i));
    end
    for (i = 2; i < 10; i++) begin
      {mpy_m, mpy_n} <= (i == 9) ? 8'h45 : {4'(i), 4'(i)};
      if (i > 3 && i < 8) q.push_back({w[i], w[i]});
      go(`OSA_OP_SQR);
    end
    repeat (4) begin
      r[7:0] = 8'($random(seed));
      {mpy_m, mpy_n} <= r[7:0];
      q.push_back({w[r[7:4]], w[r[3:0]]});
      go(`OSA_OP_DIV);
    end
    {acc_sel, acc_shift, source_operand_reg} <= 9'($random(seed));
    go(`OSA_OP_ACCADD);
    go(`OSA_OP_ACCWORD);
    repeat (4) @(posedge pclk);
    test_done;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
